// ==== rtl/urb_cfg.svh ====
// constants for the receive buffer and status block
// assumes inclusion by the package, the design modules and the bench
`ifndef URB_CFG_SVH
`define URB_CFG_SVH

// storage shape
`define URB_DATA_W    8
`define URB_DEPTH     2'h2
`define URB_CNT_EMPTY 2'h0
`define URB_CNT_ONE   2'h1

// char_size_field encodings
`define URB_SZ_5 3'h0
`define URB_SZ_6 3'h1
`define URB_SZ_7 3'h2
`define URB_SZ_8 3'h3
`define URB_SZ_9 3'h7

// data bit counts per size
`define URB_BITS_5 4'h5
`define URB_BITS_6 4'h6
`define URB_BITS_7 4'h7
`define URB_BITS_8 4'h8
`define URB_BITS_9 4'h9

// highest bit index held in the data byte
`define URB_LAST_LOW 4'h7

`endif

// ==== rtl/urb_pkg.sv ====
// types shared by the receive buffer and its two-entry store
// assumes urb_cfg.svh is on the include path
`include "urb_cfg.svh"

package urb_pkg;

  // one stored character with its flags
  typedef struct packed {
    logic                   ninth;
    logic                   fe;
    logic                   dor;
    logic                   upe;
    logic [`URB_DATA_W-1:0] data;
  } urb_entry_t;

  // status as software sees it
  typedef struct packed {
    logic rxc;
    logic fe;
    logic dor;
    logic upe;
  } urb_status_t;

  // control and frame configuration bits
  typedef struct packed {
    logic       enable;
    logic       rxc_irq_en;
    logic       global_irq_en;
    logic [2:0] char_size;
    logic       par_upper;
    logic       par_lower;
  } urb_cfg_t;

  typedef enum logic [1:0] {
    URB_IDLE,
    URB_DATA,
    URB_PAR,
    URB_STOP
  } urb_rx_state_t;

  // shift side state
  typedef struct packed {
    urb_rx_state_t state;
    logic [3:0]    idx;
    urb_entry_t    frame;
    logic          par_acc;
    logic          par_en;
    logic          par_odd;
    logic          hold;
    logic          lost;
  } urb_core_st_t;

  // store state
  typedef struct packed {
    urb_entry_t [1:0] mem;
    logic             wr_ptr;
    logic             rd_ptr;
    logic [1:0]       cnt;
  } urb_fifo_st_t;

endpackage : urb_pkg

// ==== rtl/urb_fifo2.sv ====
// two-entry receive store of characters with their flags
// assumes push is only offered when not full, flush overrides all
`include "urb_cfg.svh"

module urb_fifo2 (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 flush,
  input  wire logic                 push,
  input  urb_pkg::urb_entry_t       push_entry,
  input  wire logic                 pop,
  output urb_pkg::urb_entry_t       head,
  output logic [1:0]                count
);

  urb_pkg::urb_fifo_st_t st_reg;
  urb_pkg::urb_fifo_st_t st_next;
  logic                  push_ok;
  logic                  pop_ok;

  assign push_ok = push && (st_reg.cnt != `URB_DEPTH);
  assign pop_ok  = pop && (st_reg.cnt != `URB_CNT_EMPTY);

  always_comb begin
    st_next = st_reg;
    if (flush) begin
      st_next.wr_ptr = 1'b0;
      st_next.rd_ptr = 1'b0;
      st_next.cnt    = `URB_CNT_EMPTY;
    end else begin
      if (push_ok) begin
        st_next.mem[st_reg.wr_ptr] = push_entry;
        st_next.wr_ptr             = ~st_reg.wr_ptr;
      end
      if (pop_ok) begin
        st_next.rd_ptr = ~st_reg.rd_ptr;
      end
      case ({push_ok, pop_ok})
        2'b10:   st_next.cnt = st_reg.cnt + `URB_CNT_ONE;
        2'b01:   st_next.cnt = st_reg.cnt - `URB_CNT_ONE;
        default: st_next.cnt = st_reg.cnt;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign head  = st_reg.mem[st_reg.rd_ptr];
  assign count = st_reg.cnt;

  chk_fifo_bound: assert property (@(posedge clk) disable iff (srst)
    count <= `URB_DEPTH) else $error("store count above two");

  chk_fifo_flush: assert property (@(posedge clk) disable iff (srst)
    flush |=> count == `URB_CNT_EMPTY) else $error("flush left data");

endmodule : urb_fifo2

// ==== rtl/urb_rx_buffer.sv ====
// receive buffer, error flags and parity check of a serial receiver
// assumes an outside recovery unit gives start and voted bit strobes
//
// Operation
// - receive-complete reads one while any unread character is stored.
// - clearing receiver enable flushes the store, receive-complete drops.
// - interrupt is a level: flag and both enables set.
// - error flags stored per entry; status shows oldest entry.
// - status writes never change error flag values.
// - error flags never raise an interrupt on their own.
// - frame error is one when first stop bit was zero.
// - only the first stop bit is checked, others ignored.
// - overrun when store full, frame waiting, new start; frame lost.
// - overrun cleared when a frame moves into the store.
// - parity check runs with upper mode bit; lower picks odd/even.
// - data parity compared to parity bit, mismatch stored with char.
// - parity error only if checking was on at arrival.
// - parity error reads zero while checking is off.
// - disable is immediate; a frame in progress is dropped.
// - disabled receiver releases the serial input pin.
// - data read pops oldest entry, status moves to next.
// - on the first stop bit the frame moves into the store, or waits when full.
// - upper data bits of short frames read as zero.
// - ninth bit held per entry and shown before data read.
// - enabling the receiver takes over the serial input pin.
`include "urb_cfg.svh"

module urb_rx_buffer (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  urb_pkg::urb_cfg_t         cfg,
  input  wire logic                 serial_in_pin,
  input  wire logic                 start_detect,
  input  wire logic                 bit_strobe,
  input  wire logic                 bit_value,
  input  wire logic                 data_read,
  input  wire logic                 status_write,
  output logic                      rx_serial_in,
  output logic                      pin_override,
  output urb_pkg::urb_status_t      rx_status,
  output logic [`URB_DATA_W-1:0]    data_io_location,
  output logic                      ninth_rx_bit,
  output logic                      rx_complete_irq
);

  urb_pkg::urb_core_st_t st_reg;
  urb_pkg::urb_core_st_t st_next;
  urb_pkg::urb_entry_t   push_entry;
  urb_pkg::urb_entry_t   head;
  logic                  push;
  logic                  pop;
  logic                  full;
  logic [1:0]            count;
  logic [3:0]            nbits;

  // data bits per character for a size code
  function automatic logic [3:0] data_bits(input logic [2:0] sz);
    case (sz)
      `URB_SZ_5: data_bits = `URB_BITS_5;
      `URB_SZ_6: data_bits = `URB_BITS_6;
      `URB_SZ_7: data_bits = `URB_BITS_7;
      `URB_SZ_9: data_bits = `URB_BITS_9;
      default:   data_bits = `URB_BITS_8;
    endcase
  endfunction : data_bits

  assign nbits = data_bits(cfg.char_size);
  assign full  = (count == `URB_DEPTH);
  assign pop   = data_read && cfg.enable;

  // pin handover
  assign pin_override = cfg.enable;
  assign rx_serial_in = cfg.enable ? serial_in_pin : 1'b1;

  always_comb begin
    st_next        = st_reg;
    push           = 1'b0;
    push_entry     = st_reg.frame;
    push_entry.dor = st_reg.lost;
    if (!cfg.enable) begin
      // drop frame in progress and any waiting frame
      st_next = '0;
    end else begin
      // waiting frame moves as soon as a slot frees
      if (st_reg.hold && !full) begin
        push         = 1'b1;
        st_next.hold = 1'b0;
        st_next.lost = 1'b0;
      end
      case (st_reg.state)
        urb_pkg::URB_IDLE: begin
          if (start_detect) begin
            if (st_reg.hold && full) begin
              st_next.hold = 1'b0;
              st_next.lost = 1'b1;
            end
            st_next.frame   = '0;
            st_next.idx     = 4'h0;
            st_next.par_acc = 1'b0;
            st_next.par_en  = cfg.par_upper;
            st_next.par_odd = cfg.par_lower;
            st_next.state   = urb_pkg::URB_DATA;
          end
        end
        urb_pkg::URB_DATA: begin
          if (bit_strobe) begin
            if (st_reg.idx <= `URB_LAST_LOW) begin
              st_next.frame.data[st_reg.idx[2:0]] = bit_value;
            end else begin
              st_next.frame.ninth = bit_value;
            end
            st_next.par_acc = st_reg.par_acc ^ bit_value;
            st_next.idx     = st_reg.idx + 4'h1;
            if (st_reg.idx + 4'h1 == nbits) begin
              if (st_reg.par_en) begin
                st_next.state = urb_pkg::URB_PAR;
              end else begin
                st_next.state = urb_pkg::URB_STOP;
              end
            end
          end
        end
        urb_pkg::URB_PAR: begin
          if (bit_strobe) begin
            // even expects zero total, odd expects one
            st_next.frame.upe = st_reg.par_en
              & (st_reg.par_acc ^ bit_value ^ st_reg.par_odd);
            st_next.state = urb_pkg::URB_STOP;
          end
        end
        urb_pkg::URB_STOP: begin
          if (bit_strobe) begin
            // later stop bits are never sampled here
            st_next.frame.fe = ~bit_value;
            st_next.state    = urb_pkg::URB_IDLE;
            if (full) begin
              st_next.hold = 1'b1;
            end else begin
              push          = 1'b1;
              push_entry.fe = ~bit_value;
              st_next.lost  = 1'b0;
            end
          end
        end
        default: begin
          st_next.state = urb_pkg::URB_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  urb_fifo2 u_store (
    .clk        (clk),
    .srst       (srst),
    .flush      (!cfg.enable),
    .push       (push),
    .push_entry (push_entry),
    .pop        (pop),
    .head       (head),
    .count      (count)
  );

  // status of the oldest entry; writes never reach these flags
  always_comb begin
    rx_status.rxc = (count != `URB_CNT_EMPTY);
    rx_status.fe  = rx_status.rxc & head.fe;
    rx_status.dor = rx_status.rxc & head.dor;
    rx_status.upe = rx_status.rxc & head.upe & cfg.par_upper;
  end

  assign data_io_location = head.data;
  assign ninth_rx_bit     = head.ninth;

  // error flags take no part in the request
  assign rx_complete_irq = rx_status.rxc & cfg.rxc_irq_en
                         & cfg.global_irq_en;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_stop_taken;
    st_reg.state == urb_pkg::URB_STOP && bit_strobe && cfg.enable;
  endsequence

  sequence s_overrun;
    cfg.enable && st_reg.state == urb_pkg::URB_IDLE && start_detect
      && st_reg.hold && full;
  endsequence

  sequence s_empty_store;
    count == `URB_CNT_EMPTY && !st_reg.hold;
  endsequence

  sequence s_start_taken;
    cfg.enable && st_reg.state == urb_pkg::URB_IDLE && start_detect;
  endsequence

  sequence s_hold_ready;
    cfg.enable && st_reg.hold && !full;
  endsequence

  chk_rxc_level: assert property (
    rx_status.rxc == (count != `URB_CNT_EMPTY) && (count <= `URB_DEPTH))
    else $error("receive-complete does not match store");

  chk_disable_flush: assert property (
    !cfg.enable |=> !rx_status.rxc && st_reg.state == urb_pkg::URB_IDLE)
    else $error("disable did not flush");

  chk_irq_level: assert property (
    rx_complete_irq == (rx_status.rxc && cfg.rxc_irq_en
      && cfg.global_irq_en))
    else $error("interrupt level wrong");

  chk_err_no_irq: assert property (
    !rx_status.rxc |-> !rx_complete_irq)
    else $error("interrupt without data");

  chk_status_hold: assert property (
    status_write && !data_read && rx_status.rxc && cfg.enable
      |=> $stable(rx_status.fe) && $stable(rx_status.dor)
      && $stable(rx_status.upe))
    else $error("status write moved flags");

  chk_first_stop: assert property (
    s_stop_taken ##0 s_empty_store |=> rx_status.rxc
      && rx_status.fe == !$past(bit_value)
      && st_reg.state == urb_pkg::URB_IDLE)
    else $error("stop bit not stored as frame error");

  chk_overrun: assert property (
    s_overrun |=> st_reg.lost && !st_reg.hold)
    else $error("overrun not recorded");

  chk_overrun_clear: assert property (
    cfg.enable && push |=> !st_reg.lost)
    else $error("overrun kept after transfer");

  chk_parity_off: assert property (
    !cfg.par_upper |-> !rx_status.upe)
    else $error("parity error while checking off");

  chk_pop_advance: assert property (
    cfg.enable && data_read && count == `URB_DEPTH && !push
      |=> count == `URB_CNT_ONE)
    else $error("read did not pop");

  chk_pin_release: assert property (
    !cfg.enable |-> !pin_override && rx_serial_in)
    else $error("pin held while disabled");

  chk_start_clear: assert property (
    s_start_taken |=> st_reg.state == urb_pkg::URB_DATA
      && st_reg.idx == 4'h0 && st_reg.frame == '0)
    else $error("start did not clear the frame");

  chk_parity_latch: assert property (
    s_start_taken |=> st_reg.par_en == $past(cfg.par_upper)
      && st_reg.par_odd == $past(cfg.par_lower))
    else $error("parity mode not taken at start");

  chk_upe_gate: assert property (
    !st_reg.par_en |-> !st_reg.frame.upe)
    else $error("parity error without checking");

  chk_full_hold: assert property (
    s_stop_taken ##0 full |=> st_reg.hold && rx_status.rxc)
    else $error("frame not kept waiting");

  chk_hold_move: assert property (
    s_hold_ready |=> !st_reg.hold && !st_reg.lost && rx_status.rxc)
    else $error("waiting frame not moved");

  chk_pop_empty: assert property (
    cfg.enable && data_read && count == `URB_CNT_ONE && !push
      |=> !rx_status.rxc)
    else $error("last read left data");

  chk_flags_empty: assert property (
    !rx_status.rxc |-> !rx_status.fe && !rx_status.dor
      && !rx_status.upe)
    else $error("flags shown with empty store");

  chk_irq_gate: assert property (
    !cfg.rxc_irq_en || !cfg.global_irq_en |-> !rx_complete_irq)
    else $error("interrupt while disabled");

  chk_drop_frame: assert property (
    !cfg.enable |=> !st_reg.hold && !st_reg.lost && st_reg.frame == '0)
    else $error("disable kept a frame");

endmodule : urb_rx_buffer

// ==== test/urb_tx_model.sv ====
// far-side frame source as seen through the recovery unit
// assumes send is called at a falling edge of clk
module urb_tx_model (
  input  wire logic clk,
  output logic      serial_in_pin,
  output logic      start_detect,
  output logic      bit_strobe,
  output logic      bit_value
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    serial_in_pin = 1'b1;
    start_detect  = 1'b0;
    bit_strobe    = 1'b0;
    bit_value     = 1'b0;
  end

  // data lsb first, optional parity, one stop bit
  task automatic send(input logic [8:0] d, input int nb, input logic par_on,
                      input logic par_odd, input logic flip,
                      input logic stop);
    logic q[$];
    logic p;
    p = par_odd ^ flip;
    for (int i = 0; i < nb; i++) begin
      q.push_back(d[i]);
      p = p ^ d[i];
    end
    if (par_on) begin
      q.push_back(p);
    end
    q.push_back(stop);
    start_detect  = 1'b1;
    serial_in_pin = 1'b0;
    @(negedge clk);
    start_detect = 1'b0;
    bit_strobe   = 1'b1;
    foreach (q[i]) begin
      bit_value     = q[i];
      serial_in_pin = q[i];
      @(negedge clk);
    end
    bit_strobe    = 1'b0;
    // voted level is stale outside a strobe
    bit_value     = ~bit_value;
    serial_in_pin = 1'b1;
  endtask : send
endmodule : urb_tx_model

// ==== test/tb.sv ====
// self-checking bench of the receive buffer against a queue model
// assumes urb_pkg, urb_cfg.svh and urb_tx_model are compiled first
`include "urb_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 clk;
  logic                 srst;
  urb_pkg::urb_cfg_t    cfg;
  logic                 serial_in_pin;
  logic                 start_detect;
  logic                 bit_strobe;
  logic                 bit_value;
  logic                 data_read;
  logic                 status_write;
  logic                 rx_serial_in;
  logic                 pin_override;
  urb_pkg::urb_status_t rx_status;
  logic [7:0]           data_io_location;
  logic                 ninth_rx_bit;
  logic                 rx_complete_irq;
  logic [11:0]          exp_q[$];
  logic [2:0]           sizes[5];
  int                   seed = 32'ha312;
  int                   err_count = 0;
  int                   checks = 0;

  urb_rx_buffer urb_rx_buffer_i (
    .clk              (clk),
    .srst             (srst),
    .cfg              (cfg),
    .serial_in_pin    (serial_in_pin),
    .start_detect     (start_detect),
    .bit_strobe       (bit_strobe),
    .bit_value        (bit_value),
    .data_read        (data_read),
    .status_write     (status_write),
    .rx_serial_in     (rx_serial_in),
    .pin_override     (pin_override),
    .rx_status        (rx_status),
    .data_io_location (data_io_location),
    .ninth_rx_bit     (ninth_rx_bit),
    .rx_complete_irq  (rx_complete_irq)
  );

  urb_tx_model urb_tx_model_i (
    .clk           (clk),
    .serial_in_pin (serial_in_pin),
    .start_detect  (start_detect),
    .bit_strobe    (bit_strobe),
    .bit_value     (bit_value)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input string what, input logic [11:0] seen,
                       input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // entry layout: ninth, fe, dor, upe, data
  task automatic check_head();
    logic [11:0] h;
    logic        rxc;
    #1;
    rxc  = (exp_q.size() != 0);
    h    = rxc ? exp_q[0] : 12'h000;
    h[8] = h[8] & cfg.par_upper;
    check("status", {8'h00, rx_status}, {8'h00, rxc, h[10:8]});
    check("irq", {11'h000, rx_complete_irq},
          {11'h000, rxc & cfg.rxc_irq_en & cfg.global_irq_en});
    if (rxc) begin
      check("data", {4'h0, data_io_location}, {4'h0, h[7:0]});
      check("ninth", {11'h000, ninth_rx_bit}, {11'h000, h[11]});
    end
    check("pin", {10'h000, rx_serial_in, pin_override},
          {10'h000, cfg.enable ? serial_in_pin : 1'b1, cfg.enable});
    // back on a falling edge for the next drive
    @(negedge clk);
  endtask : check_head

  task automatic frame(input logic [2:0] sz, input logic flip,
                       input logic stop);
    int          nb;
    logic [8:0]  d;
    logic        dor;
    nb  = (sz == `URB_SZ_9) ? 9 : (sz > 3'h3) ? 8 : 5 + int'(sz);
    d   = 9'($random(seed)) & 9'((1 << nb) - 1);
    dor = (exp_q.size() == 3);
    if (dor) begin
      void'(exp_q.pop_back());
    end
    exp_q.push_back({d[8], ~stop, dor, flip & cfg.par_upper, d[7:0]});
    cfg.char_size = sz;
    urb_tx_model_i.send(d, nb, cfg.par_upper, cfg.par_lower, flip, stop);
    check_head();
  endtask : frame

  // status is compared after each read
  task automatic pop();
    data_read = 1'b1;
    @(negedge clk);
    data_read = 1'b0;
    if (exp_q.size() != 0) begin
      void'(exp_q.pop_front());
    end
    check_head();
    @(negedge clk);
  endtask : pop

  task automatic close_out();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  initial begin
    sizes        = '{`URB_SZ_5, `URB_SZ_6, `URB_SZ_7, `URB_SZ_8, `URB_SZ_9};
    srst         = 1'b1;
    cfg          = '0;
    data_read    = 1'b0;
    status_write = 1'b0;
    repeat (20) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    check_head();
    cfg.enable        = 1'b1;
    cfg.global_irq_en = 1'b1;
    // every size against off, even and odd checking
    for (int m = 0; m < 15; m++) begin
      cfg.par_upper  = (m % 3) != 0;
      cfg.par_lower  = (m % 3) == 2;
      cfg.rxc_irq_en = 1'($random(seed));
      cfg.global_irq_en = 1'($random(seed));
      frame(sizes[m / 3], 1'($random(seed)), 1'($random(seed)));
      status_write = 1'b1;
      @(negedge clk);
      status_write = 1'b0;
      check_head();
      pop();
    end
    // overrun: two stored, one waiting, another start
    cfg.par_upper  = 1'b1;
    cfg.par_lower  = 1'b0;
    cfg.rxc_irq_en = 1'b1;
    cfg.global_irq_en = 1'b1;
    frame(`URB_SZ_8, 1'b1, 1'b1);
    frame(`URB_SZ_8, 1'b0, 1'b0);
    frame(`URB_SZ_8, 1'b0, 1'b1);
    frame(`URB_SZ_8, 1'b0, 1'b1);
    cfg.par_upper = 1'b0;
    check_head();
    cfg.par_upper = 1'b1;
    pop();
    pop();
    frame(`URB_SZ_8, 1'b0, 1'b1);
    for (int k = 0; rx_status.rxc === 1'b1; k++) begin
      if (k == 8) begin
        err_count++;
        break;
      end
      pop();
    end
    // disable in mid-frame flushes and drops the frame
    frame(`URB_SZ_9, 1'b0, 1'b1);
    fork
      urb_tx_model_i.send(9'h0a5, 8, 1'b1, 1'b0, 1'b0, 1'b1);
      begin
        repeat (3) @(negedge clk);
        cfg.enable = 1'b0;
        exp_q.delete();
        @(negedge clk);
        check_head();
        cfg.enable = 1'b1;
      end
    join
    check_head();
    close_out();
  end
endmodule : tb
